//--- sfs_pkg.sv
// Package: constants and types for the serial flash port timing block
package sfs_pkg;

   // Core clock rate
   localparam int unsigned CLK_MHZ = 100;

   // Command opcodes
   localparam logic [7:0] OP_STATUS = 8'hd7;
   localparam logic [7:0] OP_EP = 8'h83;
   localparam logic [7:0] OP_PROG = 8'h88;
   localparam logic [7:0] OP_BYTE = 8'h02;
   localparam logic [7:0] OP_OTP = 8'h9b;
   localparam logic [7:0] OP_LOCK = 8'h7f;
   localparam logic [7:0] OP_XFR = 8'h53;
   localparam logic [7:0] OP_CMP = 8'h60;
   localparam logic [7:0] OP_DPD = 8'hb9;
   localparam logic [7:0] OP_RESUME = 8'hab;
   localparam logic [7:0] OP_UDPD = 8'h79;

   // Operation times in their own units
   localparam int unsigned T_EP_MS = 15;
   localparam int unsigned T_PROG_MS = 2;
   localparam int unsigned T_BYTE_US = 8;
   localparam int unsigned T_OTP_US = 200;
   localparam int unsigned T_LOCK_US = 200;
   localparam int unsigned T_XFR_US = 200;
   localparam int unsigned T_XUDPD_US = 100;
   localparam int unsigned T_RDPD_US = 35;

   // Operation times in core cycles
   localparam int unsigned CYC_EP = T_EP_MS * 1000 * CLK_MHZ;
   localparam int unsigned CYC_PROG = T_PROG_MS * 1000 * CLK_MHZ;
   localparam int unsigned CYC_BYTE = T_BYTE_US * CLK_MHZ;
   localparam int unsigned CYC_OTP = T_OTP_US * CLK_MHZ;
   localparam int unsigned CYC_LOCK = T_LOCK_US * CLK_MHZ;
   localparam int unsigned CYC_XFR = T_XFR_US * CLK_MHZ;
   localparam int unsigned CYC_XUDPD = T_XUDPD_US * CLK_MHZ;
   localparam int unsigned CYC_RDPD = T_RDPD_US * CLK_MHZ;

   // Status flags handed to the link, and their status byte bits
   localparam int unsigned FLG_W = 3;
   localparam int unsigned FLG_RDY = 0;
   localparam int unsigned FLG_PROT = 1;
   localparam int unsigned FLG_AWAKE = 2;
   localparam int unsigned STS_RDY_BIT = 7;
   localparam int unsigned STS_PROT_BIT = 1;

   // Busy timer and core states
   typedef logic [22:0] sfs_tmr_t;
   localparam sfs_tmr_t TMR_LAST = 23'h000001;
   typedef enum logic [2:0] {
      ST_IDLE, ST_BUSY, ST_DPD, ST_RESUME, ST_UDPD, ST_WAKE
   } sfs_state_t;

endpackage

//--- sfs_link_if.sv
// Interface: signals between the core logic and the link shift logic
`timescale 1ns/1ps
interface sfs_link_if;
   logic [7:0] opcode;
   logic op_vld;
   logic live;
   logic [2:0] bcnt;
   logic [sfs_pkg::FLG_W-1:0] flags;
   logic [sfs_pkg::FLG_W-1:0] flags_s;
   modport core (input opcode, input op_vld, output flags);
   modport rx (input flags, output opcode, output op_vld, output live,
      output bcnt, output flags_s);
   modport tx (input opcode, input op_vld, input live, input bcnt, input flags_s);
endinterface

//--- sfs_rx.sv
// Link receive side: samples serial input on rising clock edges
`timescale 1ns/1ps
module sfs_rx (
   // Link pins
   input wire logic i_sck,
   input wire logic i_cs_b,
   input wire logic i_si,
   // Core reset
   input wire logic i_rst_b,
   // Shift logic signals
   sfs_link_if.rx lnk
);
   typedef struct packed {
      logic [2:0] bcnt;
      logic [6:0] sh;
      logic [7:0] op;
      logic vld;
      logic [sfs_pkg::FLG_W-1:0] fs1;
      logic [sfs_pkg::FLG_W-1:0] fs2;
   } sfs_rx_st_t;

   sfs_rx_st_t q;
   sfs_rx_st_t d;
   logic live_q;
   logic frame_clr;

   // Select high or reset marks the next edge as a frame start
   assign frame_clr = i_cs_b | ~i_rst_b;

   // Frame marker, kept apart so the opcode outlives the frame
   always_ff @(posedge i_sck or posedge frame_clr) begin
      if (frame_clr) begin
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
      end
   end

   // Bit capture; idle clock level does not matter
   always_comb begin
      d = q;
      d.fs1 = lnk.flags;
      d.fs2 = q.fs1;
      d.sh = {q.sh[5:0], i_si};
      if (!live_q) begin
         d.bcnt = 3'h1;
         d.vld = 1'b0;
      end else begin
         d.bcnt = q.bcnt + 3'h1;
         if (q.bcnt == 3'h7 && !q.vld) begin
            d.op = {q.sh, i_si};
            d.vld = 1'b1;
         end
      end
   end

   always_ff @(posedge i_sck or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs to core and transmit side
   assign lnk.opcode = q.op;
   assign lnk.op_vld = q.vld;
   assign lnk.live = live_q;
   assign lnk.bcnt = q.bcnt;
   assign lnk.flags_s = q.fs2;
endmodule

//--- sfs_tx.sv
// Link transmit side: shifts status out on falling clock edges
`timescale 1ns/1ps
module sfs_tx (
   // Link pins
   input wire logic i_sck,
   input wire logic i_cs_b,
   output logic o_so,
   output logic o_so_oe_b,
   // Core reset
   input wire logic i_rst_b,
   // Shift logic signals
   sfs_link_if.tx lnk
);
   typedef struct packed {
      logic so;
      logic oe_b;
      logic [6:0] sh;
   } sfs_tx_st_t;

   sfs_tx_st_t q;
   sfs_tx_st_t d;
   logic [7:0] sts;
   logic frame_clr;

   assign frame_clr = i_cs_b | ~i_rst_b;

   // Status byte from the synchronised core flags
   always_comb begin
      sts = 8'h00;
      sts[sfs_pkg::STS_RDY_BIT] = lnk.flags_s[sfs_pkg::FLG_RDY];
      sts[sfs_pkg::STS_PROT_BIT] = lnk.flags_s[sfs_pkg::FLG_PROT];
   end

   // Status read repeats the byte; each bit changes on a falling edge
   always_comb begin
      d = q;
      if (lnk.live && lnk.op_vld && lnk.opcode == sfs_pkg::OP_STATUS &&
            lnk.flags_s[sfs_pkg::FLG_AWAKE]) begin
         d.oe_b = 1'b0;
         if (lnk.bcnt == 3'h0) begin
            d.so = sts[7];
            d.sh = sts[6:0];
         end else begin
            d.so = q.sh[6];
            d.sh = {q.sh[5:0], 1'b0};
         end
      end
   end

   // Select high releases the pin at once
   always_ff @(negedge i_sck or posedge frame_clr) begin
      if (frame_clr) begin
         q <= '{so: 1'b0, oe_b: 1'b1, sh: 7'h00};
      end else begin
         q <= d;
      end
   end

   assign o_so = q.so;
   assign o_so_oe_b = q.oe_b;
endmodule

//--- sfs_top.sv
// Top: serial flash port timing core with link-side shift logic
`timescale 1ns/1ps
// Function
// - Sample input rising, shift output falling edge
// - Clock may idle low or high at select
// - Write-protect acts and releases within 1 us
// - Sector lockdown done 200 us after select high
// - Ultra power-down: enter 3 us, wake 100 us
// - Deep power-down: enter 3 us, resume 35 us
// - Page transfer or compare done within 200 us
// - Erase-and-program page: typical 15, max 55 ms
// - Page program: typical 2, max 4 ms
// - Single byte program takes typical 8 us
// - Security area program: typical 200, max 500 us
// - Output valid within clock low below 85 MHz
// - Full-cycle mode: host samples full cycle later
module sfs_top #(
   // Long busy durations in core cycles
   parameter int unsigned P_EP_CYC = sfs_pkg::CYC_EP,
   parameter int unsigned P_PROG_CYC = sfs_pkg::CYC_PROG,
   parameter int unsigned P_OTP_CYC = sfs_pkg::CYC_OTP,
   parameter int unsigned P_LOCK_CYC = sfs_pkg::CYC_LOCK,
   parameter int unsigned P_XFR_CYC = sfs_pkg::CYC_XFR,
   parameter int unsigned P_XUDPD_CYC = sfs_pkg::CYC_XUDPD
) (
   // Core clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,

   // Serial link pins
   input wire logic i_sck,
   input wire logic i_cs_b,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe_b,

   // Write-protect pin
   input wire logic i_wp_b,

   // Device state
   output logic o_ready,
   output logic o_protect,
   output logic o_pwr_down,
   output logic o_ultra_down,
   output logic o_done,
   output logic o_reject
);

   // Core state
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic cs_s4;
      logic wp_s1;
      logic wp_s2;
      logic vld_s1;
      logic vld_s2;
      logic vld_s3;
      logic [7:0] op;
      logic got;
      sfs_pkg::sfs_state_t st;
      sfs_pkg::sfs_tmr_t tmr;
      logic rdy;
      logic prot;
      logic awake;
      logic dpd;
      logic udpd;
      logic done;
      logic rej;
   } sfs_core_st_t;

   sfs_core_st_t q;
   sfs_core_st_t d;

   // Frame events seen in the core domain
   logic cs_rise;
   logic cs_fall;
   logic vld_rise;
   logic got_now;
   logic [7:0] op_now;

   sfs_link_if lnk ();

   // Busy time of a command; zero when the command takes none
   function automatic sfs_pkg::sfs_tmr_t dur_of(input logic [7:0] op);
      sfs_pkg::sfs_tmr_t n;
      n = '0;
      case (op)
         sfs_pkg::OP_EP: begin
            n = sfs_pkg::sfs_tmr_t'(P_EP_CYC);
         end
         sfs_pkg::OP_PROG: begin
            n = sfs_pkg::sfs_tmr_t'(P_PROG_CYC);
         end
         sfs_pkg::OP_BYTE: begin
            n = sfs_pkg::sfs_tmr_t'(sfs_pkg::CYC_BYTE);
         end
         sfs_pkg::OP_OTP: begin
            n = sfs_pkg::sfs_tmr_t'(P_OTP_CYC);
         end
         sfs_pkg::OP_LOCK: begin
            n = sfs_pkg::sfs_tmr_t'(P_LOCK_CYC);
         end
         sfs_pkg::OP_XFR, sfs_pkg::OP_CMP: begin
            n = sfs_pkg::sfs_tmr_t'(P_XFR_CYC);
         end
         default: begin
            n = '0;
         end
      endcase
      return n;
   endfunction

   // Commands that alter the array and so obey write-protect
   function automatic logic is_array_write(input logic [7:0] op);
      return op == sfs_pkg::OP_EP || op == sfs_pkg::OP_PROG ||
         op == sfs_pkg::OP_BYTE;
   endfunction

   // Edge detection behind the synchronisers
   assign cs_rise = q.cs_s3 & ~q.cs_s4;
   assign cs_fall = ~q.cs_s2 & q.cs_s3;
   assign vld_rise = q.vld_s2 & ~q.vld_s3;

   // Opcode may arrive in the same cycle as the frame end
   assign got_now = q.got | vld_rise;
   assign op_now = vld_rise ? lnk.opcode : q.op;

   // Next core state
   always_comb begin
      d = q;

      // Two-stage synchronisers for pins and link levels
      d.cs_s1 = i_cs_b;
      d.cs_s2 = q.cs_s1;
      d.cs_s3 = q.cs_s2;
      d.cs_s4 = q.cs_s3;
      d.wp_s1 = i_wp_b;
      d.wp_s2 = q.wp_s1;
      d.vld_s1 = lnk.op_vld;
      d.vld_s2 = q.vld_s1;
      d.vld_s3 = q.vld_s2;

      // Event pulses last one cycle
      d.done = 1'b0;
      d.rej = 1'b0;

      // Low pin protects, high pin releases, a few cycles later
      d.prot = ~q.wp_s2;

      // Opcode tracking per frame
      if (cs_fall) begin
         d.got = 1'b0;
      end
      if (vld_rise) begin
         d.op = lnk.opcode;
         d.got = 1'b1;
      end

      // Operation sequencing; commands act when select rises
      case (q.st)
         sfs_pkg::ST_IDLE: begin
            if (cs_rise && got_now) begin
               d.got = 1'b0;
               if (op_now == sfs_pkg::OP_DPD) begin
                  d.st = sfs_pkg::ST_DPD;
               end else if (op_now == sfs_pkg::OP_UDPD) begin
                  d.st = sfs_pkg::ST_UDPD;
               end else if (dur_of(op_now) != '0) begin
                  if (is_array_write(op_now) && q.prot) begin
                     d.rej = 1'b1;
                  end else begin
                     d.st = sfs_pkg::ST_BUSY;
                     d.tmr = dur_of(op_now);
                  end
               end
            end
         end

         sfs_pkg::ST_BUSY, sfs_pkg::ST_RESUME, sfs_pkg::ST_WAKE: begin
            // Count down; ending returns to idle with a done pulse
            if (q.tmr <= sfs_pkg::TMR_LAST) begin
               d.st = sfs_pkg::ST_IDLE;
               d.tmr = '0;
               d.done = 1'b1;
            end else begin
               d.tmr = q.tmr - 1'b1;
            end
            // Anything but a status read is refused while busy
            if (cs_rise && got_now) begin
               d.got = 1'b0;
               d.rej = op_now != sfs_pkg::OP_STATUS;
            end
         end

         sfs_pkg::ST_DPD: begin
            // Only the resume command is heard in deep power-down
            if (cs_rise && got_now) begin
               d.got = 1'b0;
               if (op_now == sfs_pkg::OP_RESUME) begin
                  d.st = sfs_pkg::ST_RESUME;
                  d.tmr = sfs_pkg::sfs_tmr_t'(sfs_pkg::CYC_RDPD);
               end else begin
                  d.rej = 1'b1;
               end
            end
         end

         sfs_pkg::ST_UDPD: begin
            // Any low sample of select starts the wake-up
            if (!q.cs_s2) begin
               d.st = sfs_pkg::ST_WAKE;
               d.tmr = sfs_pkg::sfs_tmr_t'(P_XUDPD_CYC);
            end
         end

         default: begin
            d.st = sfs_pkg::ST_IDLE;
            d.tmr = '0;
         end
      endcase

      // State flags registered with the state
      d.rdy = d.st == sfs_pkg::ST_IDLE;
      d.dpd = d.st == sfs_pkg::ST_DPD || d.st == sfs_pkg::ST_RESUME;
      d.udpd = d.st == sfs_pkg::ST_UDPD || d.st == sfs_pkg::ST_WAKE;
      d.awake = !(d.dpd || d.udpd);
   end

   // Core state register
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Flags handed to the link as independent levels
   // One driver for the whole flag word: awake, protect, ready
   assign lnk.flags = {q.awake, q.prot, q.rdy};

   // Device state outputs
   assign o_ready = q.rdy;
   assign o_protect = q.prot;
   assign o_pwr_down = q.dpd;
   assign o_ultra_down = q.udpd;
   assign o_done = q.done;
   assign o_reject = q.rej;

   // Receive side on the link clock
   sfs_rx u_rx (
      .i_sck(i_sck),
      .i_cs_b(i_cs_b),
      .i_si(i_si),
      .i_rst_b(i_rst_b),
      .lnk(lnk.rx)
   );

   // Transmit side on the link clock
   sfs_tx u_tx (
      .i_sck(i_sck),
      .i_cs_b(i_cs_b),
      .o_so(o_so),
      .o_so_oe_b(o_so_oe_b),
      .i_rst_b(i_rst_b),
      .lnk(lnk.tx)
   );

endmodule

//--- sfs_properties.sv
// Checker: port-level timing relations of the flash timing core
`timescale 1ns/1ps
module sfs_properties #(
   parameter int unsigned P_EP_CYC = sfs_pkg::CYC_EP
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Watched pins
   input wire logic i_cs_b,
   input wire logic i_wp_b,
   input wire logic o_so_oe_b,
   input wire logic o_ready,
   input wire logic o_protect,
   input wire logic o_pwr_down,
   input wire logic o_ultra_down,
   input wire logic o_done,
   input wire logic o_reject
);
   localparam int unsigned BUSY_MAX = P_EP_CYC > sfs_pkg::CYC_BYTE ? P_EP_CYC : sfs_pkg::CYC_BYTE;
   localparam int unsigned LIM = BUSY_MAX + 2;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   logic [23:0] busy_q;
   logic [23:0] busy_d;
   // Length of the present busy stretch while awake
   always_comb begin
      busy_d = '0;
      if (!o_ready && !o_pwr_down && !o_ultra_down) begin
         busy_d = busy_q + 24'h000001;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_q <= '0;
      end else begin
         busy_q <= busy_d;
      end
   end
   // Protection follows the pin both ways within 100 cycles
   property p_wp_on;
      $fell(i_wp_b) |-> ##[1:100] o_protect;
   endproperty
   a_wp_on: assert property (p_wp_on) else $error("protect not applied in time");
   property p_wp_off;
      $rose(i_wp_b) |-> ##[1:100] !o_protect;
   endproperty
   a_wp_off: assert property (p_wp_off) else $error("protect not removed in time");
   // Idle refusals only come from protection
   property p_rej;
      o_reject && o_ready |-> o_protect;
   endproperty
   a_rej: assert property (p_rej) else $error("idle refusal without protect");
   // Output driver off whenever select is high
   property p_oe;
      i_cs_b |-> o_so_oe_b;
   endproperty
   a_oe: assert property (p_oe) else $error("output driven while deselected");
   // Completion always lands in the ready state
   property p_done_rdy;
      o_done |-> o_ready && !o_pwr_down && !o_ultra_down;
   endproperty
   a_done_rdy: assert property (p_done_rdy) else $error("done without ready");
   property p_resume;
      $fell(o_pwr_down) |-> o_done && o_ready;
   endproperty
   a_resume: assert property (p_resume) else $error("resume end without done");
   property p_wake;
      $fell(o_ultra_down) |-> o_done && o_ready;
   endproperty
   a_wake: assert property (p_wake) else $error("wake end without done");
   property p_rdy_excl;
      o_ready |-> !(o_pwr_down || o_ultra_down);
   endproperty
   a_rdy_excl: assert property (p_rdy_excl) else $error("ready while powered down");
   property p_busy;
      busy_q <= LIM;
   endproperty
   a_busy: assert property (p_busy) else $error("busy stretch too long");
endmodule
bind sfs_top sfs_properties #(.P_EP_CYC(P_EP_CYC)) i_props (.i_core_clk(i_core_clk),
   .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_wp_b(i_wp_b), .o_so_oe_b(o_so_oe_b),
   .o_ready(o_ready), .o_protect(o_protect), .o_pwr_down(o_pwr_down),
   .o_ultra_down(o_ultra_down), .o_done(o_done), .o_reject(o_reject));

//--- sfs_host.sv
// Host model: drives link frames in mode 0 or mode 3
`timescale 1ns/1ps
module sfs_host (
   // Link pins
   input wire logic i_so,
   output logic o_sck,
   output logic o_cs_b,
   output logic o_si
);
   localparam int HALF = 32; // 15.6 MHz, below every read limit
   // Deselected before reset release
   initial begin
      o_sck = 1'b0;
      o_cs_b = 1'b1;
      o_si = 1'b0;
   end
   // One frame; answer bits sampled a full cycle after launch
   task automatic frame(input logic cpol, input logic [7:0] op, input int nbit,
         output logic [7:0] rd);
      rd = '0;
      o_sck = cpol;
      #3;
      o_cs_b = 1'b0;
      o_si = op[7];
      for (int i = 0; i < nbit; i++) begin
         o_sck = 1'b0;
         #HALF;
         o_sck = 1'b1;
         // Next bit launched just after the rising edge
         #1;
         o_si = (i < 7) ? op[6-i] : ~o_si;
         #(HALF - 2);
         if (i >= 8) begin
            rd[15-i] = i_so;
         end
         #1;
      end
      if (!cpol) begin
         o_sck = 1'b0;
         #HALF;
      end
      o_cs_b = 1'b1;
      o_si = ~o_si;
      #40;
   endtask
   // Short select pulse that wakes the device
   task automatic wake();
      o_cs_b = 1'b0;
      #25;
      o_cs_b = 1'b1;
      #40;
   endtask
endmodule

//--- sfs_top_tb.sv
// Testbench: frames, timed operations, power-down and write-protect
`timescale 1ns/1ps
module sfs_top_tb;
   localparam int EP = 300, PR = 100, OT = 60, LK = 50, XF = 40, UD = 80;
   logic clk, rst_b, wp_b, sck, cs_b, si, so, so_oe_b;
   logic ready, prot, pd, ud, done, rej;
   logic [7:0] rd;
   int error_cnt, checks, rej_cnt;
   initial clk = 1'b0;
   always #5 clk = ~clk;
   sfs_top #(.P_EP_CYC(EP), .P_PROG_CYC(PR), .P_OTP_CYC(OT), .P_LOCK_CYC(LK),
      .P_XFR_CYC(XF), .P_XUDPD_CYC(UD)) i_dut (.i_core_clk(clk), .i_rst_b(rst_b),
      .i_sck(sck), .i_cs_b(cs_b), .i_si(si), .o_so(so), .o_so_oe_b(so_oe_b),
      .i_wp_b(wp_b), .o_ready(ready), .o_protect(prot), .o_pwr_down(pd),
      .o_ultra_down(ud), .o_done(done), .o_reject(rej));
   sfs_host i_host (.i_so(so), .o_sck(sck), .o_cs_b(cs_b), .o_si(si));
   // Refusal pulse counter
   always @(posedge clk) if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bounded wait on one state output, returns cycles waited
   task automatic wait_for(input int sel, input logic v, input int lim, output int n);
      logic [4:0] m;
      n = 0;
      m = {prot, ud, pd, done, ready};
      while (m[sel] !== v) begin
         @(posedge clk);
         #1;
         n++;
         m = {prot, ud, pd, done, ready};
         if (n > lim) begin
            check(1'b0, "timeout");
            print_verdict();
         end
      end
   endtask
   task automatic t_reset();
      repeat (3) @(posedge clk);
      check(so_oe_b === 1'b1 && ready === 1'b0, "reset outputs");
      #1 rst_b = 1'b1;
      repeat (6) @(posedge clk);
      #1 check(ready === 1'b1 && prot === 1'b0 && pd === 1'b0, "after reset");
   endtask
   task automatic t_status(input logic cpol, input logic [7:0] exp);
      i_host.frame(cpol, sfs_pkg::OP_STATUS, 16, rd);
      check(rd === exp, "status byte");
   endtask
   task automatic t_wp();
      int w;
      @(posedge clk);
      #1 wp_b = 1'b0;
      wait_for(4, 1'b1, 100, w);
      t_status(1'b1, 8'h82);
      rej_cnt = 0;
      i_host.frame(1'b0, sfs_pkg::OP_PROG, 8, rd);
      repeat (10) @(posedge clk);
      check(rej_cnt === 1 && ready === 1'b1, "protected write");
      #1 wp_b = 1'b1;
      wait_for(4, 1'b0, 100, w);
   endtask
   task automatic t_busy();
      int w;
      i_host.frame(1'b0, sfs_pkg::OP_EP, 8, rd);
      wait_for(0, 1'b0, 20, w);
      t_status(1'b1, 8'h00);
      rej_cnt = 0;
      i_host.frame(1'b1, sfs_pkg::OP_PROG, 8, rd);
      repeat (10) @(posedge clk);
      check(rej_cnt === 1 && ready === 1'b0, "busy refusal");
      wait_for(1, 1'b1, EP, w);
   endtask
   task automatic t_timed(input logic [7:0] op, input int n);
      int w;
      i_host.frame(1'b0, op, 8, rd);
      wait_for(0, 1'b0, 20, w);
      wait_for(1, 1'b1, n + 10, w);
      check(w >= n - 2 && w <= n + 2 && ready === 1'b1, "busy length");
   endtask
   task automatic t_deep();
      int w;
      i_host.frame(1'b0, sfs_pkg::OP_DPD, 8, rd);
      wait_for(2, 1'b1, 300, w);
      rej_cnt = 0;
      i_host.frame(1'b1, sfs_pkg::OP_STATUS, 16, rd);
      repeat (10) @(posedge clk);
      check(rej_cnt === 1 && rd === 8'h00 && ready === 1'b0, "deep refusal");
      i_host.frame(1'b0, sfs_pkg::OP_RESUME, 8, rd);
      wait_for(1, 1'b1, sfs_pkg::CYC_RDPD + 20, w);
      check(w + 4 >= sfs_pkg::CYC_RDPD && w <= sfs_pkg::CYC_RDPD + 8, "resume");
      check(pd === 1'b0 && ready === 1'b1, "resume state");
   endtask
   task automatic t_ultra();
      int w;
      i_host.frame(1'b1, sfs_pkg::OP_UDPD, 8, rd);
      wait_for(3, 1'b1, 300, w);
      check(ready === 1'b0, "ready in ultra");
      i_host.wake();
      wait_for(1, 1'b1, UD + 20, w);
      check(w + 8 >= UD && w <= UD + 4 && ud === 1'b0, "wake time");
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      wp_b = 1'b1;
      error_cnt = 0;
      checks = 0;
      rej_cnt = 0;
      t_reset();
      t_status(1'b0, 8'h80);
      t_status(1'b1, 8'h80);
      t_wp();
      t_busy();
      t_timed(sfs_pkg::OP_EP, EP);
      t_timed(sfs_pkg::OP_PROG, PR);
      t_timed(sfs_pkg::OP_BYTE, sfs_pkg::CYC_BYTE);
      t_timed(sfs_pkg::OP_OTP, OT);
      t_timed(sfs_pkg::OP_LOCK, LK);
      t_timed(sfs_pkg::OP_XFR, XF);
      t_timed(sfs_pkg::OP_CMP, XF);
      t_deep();
      t_ultra();
      print_verdict();
   end
endmodule
